// *** bench/dpt_control_test.sv ***
// Self-checking testbench for the output pass-through control block
`timescale 1ns/100ps
`default_nettype none
module dpt_control_test
	import dpt_pkg::*;
;
	logic clock, sys_rst = 1'h1;
	logic [1:0] outputModeBits = 2'h0;
	logic outputRunBit = 1'h0, outputAbortBit = 1'h0, outputPathResetWrite = 1'h0, globalResetWrite = 1'h0;
	dpt_sync_cfg_t syncConfigWrite = '0;
	logic syncConfigStrobe = 1'h0, errorClear = 1'h0, extClk = 1'h0, extRun = 1'h0, trigIn = 1'h1, inTrig = 1'h1;
	logic [3:0] internalSamplePulse = 4'h0;
	logic [7:0] pulseCnt = 8'h00, burstCount = 8'h00;
	logic burstGo = 1'h0, busy, chanOneWrite, chanTwoWrite;
	logic [11:0] burstBase = 12'h000, hostWriteData, chanOneSample, chanTwoSample;
	dpt_err_t errorStatus;
	dpt_sync_cfg_t syncConfig;
	logic errorInterrupt, output_sync_confirmed, outputActive, samplePulse, output_start_trigger_out, sampleValid;
	logic inputStartDetected, sampleExport;
	int error_cnt = 0, comparisons = 0;

	dpt_control dut (.clock(clock), .sys_rst(sys_rst), .outputModeBits(outputModeBits), .outputRunBit(outputRunBit),
		.outputAbortBit(outputAbortBit), .outputPathResetWrite(outputPathResetWrite),
		.globalResetWrite(globalResetWrite), .syncConfigWrite(syncConfigWrite), .syncConfigStrobe(syncConfigStrobe),
		.chanOneWrite(chanOneWrite), .chanTwoWrite(chanTwoWrite), .hostWriteData(hostWriteData),
		.internalSamplePulse(internalSamplePulse), .external_sample_clock_in(extClk),
		.output_start_trigger_in(trigIn), .input_start_trigger_in(inTrig), .errorClear(errorClear),
		.errorStatus(errorStatus), .errorInterrupt(errorInterrupt), .syncConfig(syncConfig),
		.output_sync_confirmed(output_sync_confirmed), .outputActive(outputActive), .samplePulse(samplePulse),
		.sample_clock_export(sampleExport), .output_start_trigger_out(output_start_trigger_out),
		.inputStartDetected(inputStartDetected),
		.chanOneSample(chanOneSample), .chanTwoSample(chanTwoSample), .sampleValid(sampleValid));

	dpt_host_model host (.clock(clock), .sys_rst(sys_rst), .burstGo(burstGo), .burstCount(burstCount),
		.burstBase(burstBase), .busy(busy), .chanOneWrite(chanOneWrite), .chanTwoWrite(chanTwoWrite),
		.hostWriteData(hostWriteData));

	// ----------------------------------------------------------------
	// Clock, sample sources and closing
	// ----------------------------------------------------------------
	initial begin
		clock = 1'h0;
		forever #25 clock = ~clock;
	end

	// Source k pulses every 4+k cycles; external pin idles low outside runs
	always_ff @(posedge clock) begin
		pulseCnt <= pulseCnt + 8'h01;
		for (int k = 0; k < 4; k++) begin
			internalSamplePulse[k] <= (int'(pulseCnt) % (4 + k)) == 0;
		end
		if (!extRun) begin
			extClk <= 1'h0;
		end else if (pulseCnt[1:0] == 2'h0) begin
			extClk <= ~extClk;
		end
	end

	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		#(50 * 20000);
		error_cnt++;
		close_out();
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic set_cfg(input dpt_sync_cfg_t c);
		@(posedge clock);
		syncConfigWrite <= c;
		syncConfigStrobe <= 1'h1;
		@(posedge clock);
		syncConfigStrobe <= 1'h0;
		tick(1);
		chk("syncConfig", 32'(syncConfig), 32'(c));
	endtask

	task automatic burst(input logic [11:0] base, input logic [7:0] n);
		int w;
		@(posedge clock);
		burstBase <= base;
		burstCount <= n;
		burstGo <= 1'h1;
		@(posedge clock);
		burstGo <= 1'h0;
		tick(2);
		for (w = 0; w < 300 && busy === 1'h1; w++) tick(1);
		tick(2);
	endtask

	task automatic take(input logic [11:0] exp);
		int w;
		tick(1);
		for (w = 0; w < 200 && sampleValid !== 1'h1; w++) tick(1);
		chk("sampleValid", 32'(sampleValid), 32'h1);
		chk("chanOneSample", 32'(chanOneSample), 32'(exp));
		chk("chanTwoSample", 32'(chanTwoSample), 32'(exp));
	endtask

	task automatic wait_conf;
		int w;
		for (w = 0; w < 100 && output_sync_confirmed !== 1'h1; w++) tick(1);
	endtask

	task automatic count_pulses(input int n, output int c, output int d);
		c = 0;
		d = 0;
		repeat (n) begin
			tick(1);
			c += (samplePulse === 1'h1);
			d += (inputStartDetected === 1'h1);
		end
	endtask

	task automatic stop_all;
		@(posedge clock);
		outputRunBit <= 1'h0;
		outputAbortBit <= 1'h1;
		@(posedge clock);
		outputAbortBit <= 1'h0;
		outputPathResetWrite <= 1'h1;
		errorClear <= 1'h1;
		@(posedge clock);
		outputPathResetWrite <= 1'h0;
		errorClear <= 1'h0;
		tick(2);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_reset;
		chk("syncConfig", 32'(syncConfig), 32'h0);
		chk("edgeLevel", 32'(syncConfig.triggerEdgeLevelSelect), 32'(DPT_TRIG_LEVEL));
		chk("errorStatus", 32'(errorStatus), 32'h0);
		chk("triggerOut", 32'(output_start_trigger_out), 32'h1);
	endtask

	task automatic test_clock_select;
		logic p;
		for (int s = 0; s < 4; s++) begin
			set_cfg({DPT_SYNC_MASTER, 2'(s), 3'h0});
			p = internalSamplePulse[s];
			repeat (24) begin
				tick(1);
				chk("samplePulse", 32'(samplePulse), 32'(internalSamplePulse[s]));
				chk("sampleExport", 32'(sampleExport), 32'(p));
				chk("inputStart", 32'(inputStartDetected), 32'(internalSamplePulse[s]));
				p = internalSamplePulse[s];
			end
		end
		set_cfg('0);
	endtask

	task automatic test_stream;
		burst(12'h0a0, 8'h04);
		@(posedge clock);
		outputModeBits <= 2'h1;
		outputRunBit <= 1'h1;
		tick(20);
		chk("outputActive", 32'(outputActive), 32'h0);
		@(posedge clock);
		outputModeBits <= DPT_MODE_PASS_THROUGH;
		wait_conf();
		chk("confirmed", 32'(output_sync_confirmed), 32'h1);
		chk("triggerOut", 32'(output_start_trigger_out), 32'h0);
		for (int i = 0; i < 4; i++) take(12'h0a0 + 12'(i));
		@(posedge clock);
		outputRunBit <= 1'h0;
		tick(30);
		chk("underflow", 32'(errorStatus.underflow), 32'h1);
		chk("interrupt", 32'(errorInterrupt), 32'h1);
		chk("outputActive", 32'(outputActive), 32'h1);
		stop_all();
	endtask

	task automatic test_abort;
		int c;
		burst(12'h1b0, 8'h06);
		@(posedge clock);
		outputRunBit <= 1'h1;
		take(12'h1b0);
		take(12'h1b1);
		@(posedge clock);
		outputAbortBit <= 1'h1;
		outputRunBit <= 1'h0;
		c = 0;
		repeat (20) begin
			tick(1);
			c += (sampleValid === 1'h1);
		end
		chk("validWhileAborted", 32'(c), 32'h0);
		chk("outputActive", 32'(outputActive), 32'h0);
		@(posedge clock);
		outputAbortBit <= 1'h0;
		outputRunBit <= 1'h1;
		take(12'h1b2);
		stop_all();
	endtask

	task automatic test_overflow;
		burst(12'h2c0, 8'h11);
		chk("overflow", 32'(errorStatus.overflow), 32'h1);
		@(posedge clock);
		globalResetWrite <= 1'h1;
		errorClear <= 1'h1;
		@(posedge clock);
		globalResetWrite <= 1'h0;
		errorClear <= 1'h0;
		tick(1);
		chk("errorStatus", 32'(errorStatus), 32'h0);
		@(posedge clock);
		outputRunBit <= 1'h1;
		tick(60);
		chk("underflow", 32'(errorStatus.underflow), 32'h1);
		stop_all();
	endtask

	task automatic test_master_ext;
		set_cfg({DPT_SYNC_MASTER, 2'h0, 1'h0, 1'h1, DPT_TRIG_EDGE});
		@(posedge clock);
		trigIn <= 1'h0;
		tick(12);
		@(posedge clock);
		outputRunBit <= 1'h1;
		tick(40);
		chk("edgeHeldLow", 32'(output_sync_confirmed), 32'h0);
		@(posedge clock);
		trigIn <= 1'h1;
		tick(8);
		@(posedge clock);
		trigIn <= 1'h0;
		wait_conf();
		chk("edgeStart", 32'(output_sync_confirmed), 32'h1);
		stop_all();
		set_cfg({DPT_SYNC_MASTER, 2'h0, 1'h0, 1'h1, DPT_TRIG_LEVEL});
		@(posedge clock);
		outputRunBit <= 1'h1;
		wait_conf();
		chk("levelStart", 32'(output_sync_confirmed), 32'h1);
		@(posedge clock);
		trigIn <= 1'h1;
		stop_all();
		set_cfg('0);
	endtask

	task automatic test_slave;
		int c, d;
		set_cfg({DPT_SYNC_SLAVE, 2'h0, 1'h0, DPT_START_SOFTWARE, DPT_TRIG_EDGE});
		count_pulses(40, c, d);
		chk("pulsesNoPin", 32'(c), 32'h0);
		@(posedge clock);
		extRun <= 1'h1;
		count_pulses(40, c, d);
		chk("pulsesFromPin", 32'(c > 0), 32'h1);
		chk("inputStartIdle", 32'(d), 32'h0);
		@(posedge clock);
		outputRunBit <= 1'h1;
		inTrig <= 1'h0;
		count_pulses(40, c, d);
		chk("confirmedEarly", 32'(output_sync_confirmed), 32'h0);
		chk("inputStartOwnPin", 32'(d > 0), 32'h1);
		@(posedge clock);
		inTrig <= 1'h1;
		trigIn <= 1'h0;
		wait_conf();
		chk("confirmed", 32'(output_sync_confirmed), 32'h1);
		stop_all();
		@(posedge clock);
		outputRunBit <= 1'h1;
		wait_conf();
		chk("levelInSlave", 32'(output_sync_confirmed), 32'h1);
		@(posedge clock);
		trigIn <= 1'h1;
		extRun <= 1'h0;
		stop_all();
		set_cfg('0);
	endtask

	initial begin
		repeat (8) @(posedge clock);
		sys_rst <= 1'h0;
		tick(2);
		test_reset();
		test_clock_select();
		test_stream();
		test_abort();
		test_overflow();
		test_master_ext();
		test_slave();
		close_out();
	end
endmodule
`default_nettype wire

// *** bench/dpt_host_model.sv ***
// Host-side model that fills both output FIFOs in bursts
`timescale 1ns/100ps
`default_nettype none
module dpt_host_model
	import dpt_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Burst request
	input wire logic burstGo,
	input wire logic [7:0] burstCount,
	input wire logic [DPT_DATA_W-1:0] burstBase,
	output logic busy,
	// FIFO write side
	output logic chanOneWrite,
	output logic chanTwoWrite,
	output logic [DPT_DATA_W-1:0] hostWriteData
);
	logic [7:0] remain_r;
	logic [7:0] index_r;

	assign busy = (remain_r != 8'h00) || chanOneWrite;

	// One word to both channels per cycle; idle data bus keeps changing
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			remain_r <= 8'h00;
			index_r <= 8'h00;
			chanOneWrite <= 1'h0;
			chanTwoWrite <= 1'h0;
			hostWriteData <= '0;
		end else if (burstGo) begin
			remain_r <= burstCount;
			index_r <= 8'h00;
			chanOneWrite <= 1'h0;
			chanTwoWrite <= 1'h0;
		end else if (remain_r != 8'h00) begin
			chanOneWrite <= 1'h1;
			chanTwoWrite <= 1'h1;
			hostWriteData <= burstBase + DPT_DATA_W'(index_r);
			index_r <= index_r + 8'h01;
			remain_r <= remain_r - 8'h01;
		end else begin
			chanOneWrite <= 1'h0;
			chanTwoWrite <= 1'h0;
			hostWriteData <= ~hostWriteData;
		end
	end
endmodule
`default_nettype wire

// *** design/dpt_control.sv ***
// Output pass-through control with master/slave start synchronization
`timescale 1ns/100ps
`default_nettype none

module dpt_control
	import dpt_pkg::*;
#(
	parameter int FIFO_DEPTH = DPT_FIFO_DEPTH,
	parameter int DATA_W = DPT_DATA_W
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Host configuration and control
	input wire logic [1:0] outputModeBits,
	input wire logic outputRunBit,
	input wire logic outputAbortBit,
	input wire logic outputPathResetWrite,
	input wire logic globalResetWrite,
	input wire dpt_sync_cfg_t syncConfigWrite,
	input wire logic syncConfigStrobe,
	// Host FIFO write ports
	input wire logic chanOneWrite,
	input wire logic chanTwoWrite,
	input wire logic [DATA_W-1:0] hostWriteData,
	// Sample clock sources, internal pulses in the clock domain and the external clock pin
	input wire logic [3:0] internalSamplePulse,
	input wire logic external_sample_clock_in,
	// Start trigger pins
	input wire logic output_start_trigger_in,
	input wire logic input_start_trigger_in,
	// Error status
	input wire logic errorClear,
	output dpt_err_t errorStatus,
	output logic errorInterrupt,
	// Status and outputs
	output dpt_sync_cfg_t syncConfig,
	output logic output_sync_confirmed,
	output logic outputActive,
	output logic samplePulse,
	output logic sample_clock_export,
	output logic output_start_trigger_out,
	output logic inputStartDetected,
	output logic [DATA_W-1:0] chanOneSample,
	output logic [DATA_W-1:0] chanTwoSample,
	output logic sampleValid
);
	initial begin
		if (DATA_W < 1 || FIFO_DEPTH < 2) begin
			$error("unsupported width or depth");
		end
	end

	// ----------------------------------------------------------------
	// Configuration register
	// ----------------------------------------------------------------
	dpt_sync_cfg_t syncCfg_r;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			syncCfg_r <= '{syncSlave: DPT_SYNC_MODE_RST, clockSourceSelect: 2'h0,
				inputStartSourceSelect: DPT_START_SOFTWARE, outputStartSourceSelect: DPT_START_SOFTWARE,
				triggerEdgeLevelSelect: DPT_TRIG_MODE_RST};
		end else if (syncConfigStrobe) begin
			syncCfg_r <= syncConfigWrite;
		end
	end
	assign syncConfig = syncCfg_r;

	logic isSlave;
	assign isSlave = (syncCfg_r.syncSlave == DPT_SYNC_SLAVE);

	// ----------------------------------------------------------------
	// Pin synchronizers
	// ----------------------------------------------------------------
	logic extClkLevel;
	logic outTrigLevel;
	logic inTrigLevel;

	dpt_pin_sync #(.RESET_LEVEL(1'h0)) uClkSync (
		.clock(clock),
		.sys_rst(sys_rst),
		.pinIn(external_sample_clock_in),
		.level(extClkLevel)
	);
	dpt_pin_sync #(.RESET_LEVEL(1'h1)) uOutTrigSync (
		.clock(clock),
		.sys_rst(sys_rst),
		.pinIn(output_start_trigger_in),
		.level(outTrigLevel)
	);
	dpt_pin_sync #(.RESET_LEVEL(1'h1)) uInTrigSync (
		.clock(clock),
		.sys_rst(sys_rst),
		.pinIn(input_start_trigger_in),
		.level(inTrigLevel)
	);

	// ----------------------------------------------------------------
	// Sample pulse selection
	// ----------------------------------------------------------------
	logic extClkPrev_r;
	logic outTrigPrev_r;
	logic inTrigPrev_r;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			extClkPrev_r <= 1'h0;
			outTrigPrev_r <= 1'h1;
			inTrigPrev_r <= 1'h1;
		end else begin
			extClkPrev_r <= extClkLevel;
			outTrigPrev_r <= outTrigLevel;
			inTrigPrev_r <= inTrigLevel;
		end
	end

	// Slave takes the external clock, master the selected internal source
	assign samplePulse = isSlave ? (extClkLevel && !extClkPrev_r)
		: internalSamplePulse[syncCfg_r.clockSourceSelect];

	logic sampleExport_r;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sampleExport_r <= 1'h0;
		end else begin
			sampleExport_r <= samplePulse;
		end
	end
	assign sample_clock_export = sampleExport_r;

	// ----------------------------------------------------------------
	// Start event detection
	// ----------------------------------------------------------------
	logic useEdge;
	logic outUsesExternal;
	logic inUsesExternal;
	logic outEdgeSeen_r;
	logic inEdgeSeen_r;
	logic outExtEvent;
	logic inExtEvent;

	// Slave ignores both select bits and the edge/level bit
	assign useEdge = !isSlave && (syncCfg_r.triggerEdgeLevelSelect == DPT_TRIG_EDGE);
	assign outUsesExternal = isSlave || syncCfg_r.outputStartSourceSelect;
	assign inUsesExternal = isSlave || syncCfg_r.inputStartSourceSelect;

	// Falling edges are latched until the next sample pulse takes them
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			outEdgeSeen_r <= 1'h0;
			inEdgeSeen_r <= 1'h0;
		end else begin
			outEdgeSeen_r <= (outEdgeSeen_r && !samplePulse) || (outTrigPrev_r && !outTrigLevel);
			inEdgeSeen_r <= (inEdgeSeen_r && !samplePulse) || (inTrigPrev_r && !inTrigLevel);
		end
	end

	assign outExtEvent = useEdge ? (outEdgeSeen_r || (outTrigPrev_r && !outTrigLevel)) : !outTrigLevel;
	assign inExtEvent = useEdge ? (inEdgeSeen_r || (inTrigPrev_r && !inTrigLevel)) : !inTrigLevel;
	assign inputStartDetected = inUsesExternal ? (inExtEvent && samplePulse) : samplePulse;

	// ----------------------------------------------------------------
	// Output process state machine
	// ----------------------------------------------------------------
	dpt_state_t state_r;
	logic ptmSelected;
	logic pathReset;
	logic startEvent;
	logic streamRead;

	assign ptmSelected = (outputModeBits == DPT_MODE_PASS_THROUGH);
	assign pathReset = outputPathResetWrite || globalResetWrite;
	assign startEvent = outUsesExternal ? (outExtEvent && samplePulse) : 1'h1;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= DPT_IDLE;
		end else if (pathReset || outputAbortBit || !ptmSelected) begin
			state_r <= DPT_IDLE;
		end else begin
			unique case (state_r)
				DPT_IDLE: begin
					if (outputRunBit) begin
						state_r <= DPT_ARMED;
					end
				end
				DPT_ARMED: begin
					if (!outputRunBit) begin
						state_r <= DPT_IDLE;
					end else if (startEvent) begin
						state_r <= DPT_CONFIRMED;
					end
				end
				DPT_CONFIRMED: begin
					if (samplePulse) begin
						state_r <= DPT_STREAMING;
					end
				end
				DPT_STREAMING: begin
					state_r <= DPT_STREAMING;
				end
			endcase
		end
	end

	// Confirmation appears at the sample pulse after the start event
	logic syncOk_r;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			syncOk_r <= 1'h0;
		end else if (state_r == DPT_IDLE || pathReset || outputAbortBit) begin
			syncOk_r <= 1'h0;
		end else if (state_r != DPT_ARMED && samplePulse) begin
			syncOk_r <= 1'h1;
		end
	end
	assign output_sync_confirmed = syncOk_r;
	assign outputActive = (state_r == DPT_STREAMING);

	logic trigOut_r;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			trigOut_r <= 1'h1;
		end else begin
			trigOut_r <= !(state_r == DPT_CONFIRMED || state_r == DPT_STREAMING);
		end
	end
	assign output_start_trigger_out = trigOut_r;

	// ----------------------------------------------------------------
	// Output FIFOs
	// ----------------------------------------------------------------
	assign streamRead = outputActive && samplePulse && !outputAbortBit && !pathReset;

	logic [1:0] writeRefused;
	logic [1:0] readRefused;
	logic [1:0] fifoWrite;
	logic [DATA_W-1:0] fifoData [2];

	assign fifoWrite = {chanTwoWrite, chanOneWrite};

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : gChan
			dpt_out_fifo #(.DEPTH(FIFO_DEPTH), .WIDTH(DATA_W)) uFifo (
				.clock(clock),
				.sys_rst(sys_rst),
				.clearPointers(pathReset),
				.writeStrobe(fifoWrite[ch]),
				.writeData(hostWriteData),
				.readStrobe(streamRead),
				.readData(fifoData[ch]),
				.full(),
				.empty(),
				.writeRefused(writeRefused[ch]),
				.readRefused(readRefused[ch])
			);
		end
	endgenerate
	assign chanOneSample = fifoData[0];
	assign chanTwoSample = fifoData[1];

	logic sampleValid_r;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sampleValid_r <= 1'h0;
		end else begin
			sampleValid_r <= streamRead && (readRefused == 2'h0);
		end
	end
	assign sampleValid = sampleValid_r;

	// ----------------------------------------------------------------
	// Error flags, set wins over clear
	// ----------------------------------------------------------------
	dpt_err_t err_r;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			err_r <= '0;
		end else begin
			err_r.overflow <= (|writeRefused) || (err_r.overflow && !errorClear);
			err_r.underflow <= (|readRefused) || (err_r.underflow && !errorClear);
		end
	end
	assign errorStatus = err_r;
	assign errorInterrupt = err_r.overflow || err_r.underflow;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Nothing that ends the process is present this cycle
	sequence keepGoingSeq;
		ptmSelected && !outputAbortBit && !pathReset;
	endsequence

	// Armed controller sees its start event
	sequence armSeq;
		(state_r == DPT_ARMED) && outputRunBit && startEvent;
	endsequence

	sequence confirmSeq;
		(state_r == DPT_CONFIRMED) && samplePulse;
	endsequence

	ovf_set_a: assert property (@(posedge clock) disable iff (sys_rst)
		(|writeRefused) |=> errorStatus.overflow) else $error("overflow flag not set");
	uvf_set_a: assert property (@(posedge clock) disable iff (sys_rst)
		(|readRefused) |=> errorStatus.underflow) else $error("underflow flag not set");
	err_keeps_stream_a: assert property (@(posedge clock) disable iff (sys_rst)
		(outputActive ##0 keepGoingSeq) |=> outputActive) else $error("streaming stopped without abort");
	abort_stops_a: assert property (@(posedge clock) disable iff (sys_rst)
		outputAbortBit |=> !outputActive && !sampleValid) else $error("abort did not stop output");
	start_waits_a: assert property (@(posedge clock) disable iff (sys_rst)
		(armSeq ##0 keepGoingSeq) |=> (state_r == DPT_CONFIRMED) && !output_sync_confirmed)
		else $error("confirmation came too early");
	confirm_then_run_a: assert property (@(posedge clock) disable iff (sys_rst)
		(confirmSeq ##0 keepGoingSeq) |=> outputActive && output_sync_confirmed)
		else $error("output did not start after confirmation");
	slave_clock_a: assert property (@(posedge clock) disable iff (sys_rst)
		isSlave |-> (samplePulse == $rose(extClkLevel))) else $error("slave clock not external");
	slave_level_a: assert property (@(posedge clock) disable iff (sys_rst)
		isSlave |-> !useEdge && outUsesExternal && inUsesExternal) else $error("slave start handling wrong");
	irq_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
		errorInterrupt == (errorStatus != 2'h0)) else $error("interrupt does not follow flags");
endmodule
`default_nettype wire

// *** design/dpt_out_fifo.sv ***
// Output sample FIFO with host write port and sample-clock read port
`timescale 1ns/100ps
`default_nettype none
module dpt_out_fifo
	import dpt_pkg::*;
#(
	parameter int DEPTH = DPT_FIFO_DEPTH,
	parameter int WIDTH = DPT_DATA_W
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clearPointers,
	// Host write side
	input wire logic writeStrobe,
	input wire logic [WIDTH-1:0] writeData,
	// Sample read side
	input wire logic readStrobe,
	output logic [WIDTH-1:0] readData,
	// Status
	output logic full,
	output logic empty,
	output logic writeRefused,
	output logic readRefused
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
			$error("FIFO depth must be a power of two of at least 2");
		end
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_r;
	logic [AW:0] rdPtr_r;
	logic [WIDTH-1:0] readData_r;
	logic doWrite;
	logic doRead;

	assign full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
	assign empty = (wrPtr_r == rdPtr_r);
	assign doWrite = writeStrobe && !full;
	assign doRead = readStrobe && !empty;
	assign writeRefused = writeStrobe && full;
	assign readRefused = readStrobe && empty;

	always_ff @(posedge clock) begin
		if (doWrite) begin
			mem[wrPtr_r[AW-1:0]] <= writeData;
		end
	end

	// Write pointer moves on every accepted host write, except when clearPointers returns it to zero
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wrPtr_r <= '0;
		end else if (clearPointers) begin
			wrPtr_r <= '0;
		end else if (doWrite) begin
			wrPtr_r <= wrPtr_r + 1'b1;
		end
	end

	// Read pointer moves only on a pointer clear or on a read from a non-empty FIFO
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rdPtr_r <= '0;
		end else if (clearPointers) begin
			rdPtr_r <= '0;
		end else if (doRead) begin
			rdPtr_r <= rdPtr_r + 1'b1;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			readData_r <= '0;
		end else if (doRead) begin
			readData_r <= mem[rdPtr_r[AW-1:0]];
		end
	end

	assign readData = readData_r;

	wr_full_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		(writeStrobe && full && !clearPointers) |=> $stable(wrPtr_r))
		else $error("write pointer moved on full FIFO");
	rd_empty_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		(readStrobe && empty && !clearPointers) |=> $stable(rdPtr_r))
		else $error("read pointer moved on empty FIFO");
endmodule
`default_nettype wire

// *** design/dpt_pin_sync.sv ***
// Three-stage input synchronizer with agreement filter
`timescale 1ns/100ps
`default_nettype none
module dpt_pin_sync
	import dpt_pkg::*;
#(
	parameter logic RESET_LEVEL = 1'h1
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Pin and filtered level
	input wire logic pinIn,
	output logic level
);
	logic [DPT_PIN_STAGES-1:0] stage_r;
	logic level_r;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			stage_r <= {DPT_PIN_STAGES{RESET_LEVEL}};
		end else begin
			stage_r <= {stage_r[DPT_PIN_STAGES-2:0], pinIn};
		end
	end

	// Level changes only once stages two and three agree
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			level_r <= RESET_LEVEL;
		end else if (stage_r[1] == stage_r[2]) begin
			level_r <= stage_r[2];
		end
	end

	assign level = level_r;
endmodule
`default_nettype wire

// *** design/dpt_pkg.sv ***
// Package for the output pass-through and synchronization control block
package dpt_pkg;

	// ----------------------------------------------------------------
	// Modes and selections
	// ----------------------------------------------------------------
	localparam logic [1:0] DPT_MODE_PASS_THROUGH = 2'h2;
	localparam logic DPT_SYNC_MASTER = 1'h0;
	localparam logic DPT_SYNC_SLAVE = 1'h1;
	localparam logic DPT_TRIG_LEVEL = 1'h0;
	localparam logic DPT_TRIG_EDGE = 1'h1;
	localparam logic DPT_START_SOFTWARE = 1'h0;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic DPT_SYNC_MODE_RST = 1'h0;
	localparam logic DPT_TRIG_MODE_RST = 1'h0;
	localparam int DPT_PIN_STAGES = 3;
	localparam int DPT_FIFO_DEPTH = 16;
	localparam int DPT_DATA_W = 12;

	typedef enum {
		DPT_IDLE,
		DPT_ARMED,
		DPT_CONFIRMED,
		DPT_STREAMING
	} dpt_state_t;

	// Synchronization configuration as the host sets it
	typedef struct packed {
		logic syncSlave;
		logic [1:0] clockSourceSelect;
		logic inputStartSourceSelect;
		logic outputStartSourceSelect;
		logic triggerEdgeLevelSelect;
	} dpt_sync_cfg_t;

	// Error status flags
	typedef struct packed {
		logic overflow;
		logic underflow;
	} dpt_err_t;

endpackage
